/* File: rtl/smcfg_pkg.sv */
// Contract
// RULE1 - device only answers, never starts transfers
// RULE2 - every register type reachable, read and write
// RULE3 - address: straps in bits 2..0, fixed upper
// RULE4 - straps low gives address 68h, write D0h; the code gives 58h, write B0h
// RULE5 - address byte bit 0: 0 write, 1 read
// RULE6 - receiver acks each byte, low is ack
// RULE7 - device drives, releases and receives both lines
// RULE8 - setup offset byte is register address 7:0
// RULE9 - port byte selects ports 0 to 2
// RULE10 - write: setup transaction, then data transaction
// RULE11 - write data: first byte low, second high
// RULE12 - read: setup, command, repeated start, two bytes
// RULE13 - read data: low byte first, high second
// RULE14 - latched offset and port reused until replaced
// RULE15 - reserved port: no write, reads return zero
package smcfg_pkg;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 10000; // 100 kHz bus clock
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // ****************************************************
  // address and protocol values
  // ****************************************************
  localparam logic [3:0] ADDR_FIXED = 4'hb; // bits 6..3 = 1,0,1,1
  localparam logic WR_BIT = 1'b0;
  localparam logic RD_BIT = 1'b1;
  localparam logic ACK_BIT = 1'b0;
  localparam logic NACK_BIT = 1'b1;
  localparam logic [7:0] CMD_CODE = 8'h08;
  localparam logic [7:0] PORT_LAST = 8'h02;
  localparam logic [15:0] RDATA_RESV = 16'h0000;

  // host line operations
  typedef enum logic [1:0] {
    SMCFG_OP_START = 2'b00,
    SMCFG_OP_TX = 2'b01,
    SMCFG_OP_RX = 2'b10,
    SMCFG_OP_STOP = 2'b11
  } smcfg_op_t;

endpackage : smcfg_pkg

/* File: rtl/smcfg_if.sv */
`timescale 1ns/1ps
// ****************************************************
// two-wire management link, open drain with pull-ups
// ****************************************************
interface smcfg_if;
  logic dev_scl_out;
  logic dev_scl_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic scl;
  logic sda;

  // wired-and: a line is low when any enabled driver pulls it low
  assign scl = ~((dev_scl_oe & ~dev_scl_out) |
                 (host_scl_oe & ~host_scl_out));
  assign sda = ~((dev_sda_oe & ~dev_sda_out) |
                 (host_sda_oe & ~host_sda_out));

  modport dev (
    input scl, sda,
    output dev_scl_out, dev_scl_oe, dev_sda_out, dev_sda_oe
  );
  modport host (
    input scl, sda,
    output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe
  );
endinterface : smcfg_if

/* File: rtl/smcfg_dev.sv */
`timescale 1ns/1ps
// ****************************************************
// configuration access target on the management link
// ****************************************************
module smcfg_dev
  import smcfg_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // management link
  smcfg_if.dev link,
  // address straps
  input wire logic [2:0] strap_in,
  // configuration register side
  output logic cfg_wr_out,
  output logic cfg_rd_out,
  output logic [7:0] cfg_offset_out,
  output logic [7:0] cfg_port_out,
  output logic [15:0] cfg_wdata_out,
  input wire logic [15:0] cfg_rdata_in,
  input wire logic cfg_rvalid_in
);

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_RX = 3'b001,
    D_ACK = 3'b010,
    D_HOLD = 3'b011,
    D_TX = 3'b100,
    D_TACK = 3'b101
  } smcfg_dst_t;

  // ****************************************************
  // line synchronisers
  // ****************************************************
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic [2:0] strap_m, strap_s;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [6:0] my_addr;

  // third stage feeds edge detection only, never the first
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      strap_m <= 3'h0;
      strap_s <= 3'h0;
    end else begin
      scl_m <= link.scl; // [RULE7]
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= link.sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
      strap_m <= strap_in;
      strap_s <= strap_m;
    end
  end

  // edges and bus conditions; start/stop only with the clock high
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
  assign my_addr = {ADDR_FIXED, strap_s}; // [RULE3] [RULE4]

  // ****************************************************
  // protocol engine
  // ****************************************************
  smcfg_dst_t st, next_st;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] sh, next_sh;
  logic [2:0] idx, next_idx;
  logic rd, next_rd;
  logic [7:0] b_lo, next_b_lo;
  logic [7:0] b_hi, next_b_hi;
  logic armed, next_armed;
  logic [7:0] offset, next_offset;
  logic [7:0] port, next_port;
  logic [15:0] rdata, next_rdata;
  logic rdy, next_rdy;
  logic tx_hi, next_tx_hi;
  logic m_ack, next_m_ack;
  logic sda_oe, next_sda_oe;
  logic scl_oe, next_scl_oe;
  logic wr_pulse, next_wr_pulse;
  logic rd_pulse, next_rd_pulse;
  logic [15:0] wdata, next_wdata;
  logic byte_ok;
  logic [7:0] tx_byte;

  // acceptance of the byte just shifted in, by its place
  always_comb begin
    case (idx)
      3'h0: byte_ok = (sh[7:1] == my_addr); // [RULE4]
      3'h1: byte_ok = (sh == CMD_CODE); // [RULE10]
      3'h2: byte_ok = 1'b1;
      3'h3: byte_ok = 1'b1;
      default: byte_ok = 1'b0; // surplus bytes are refused
    endcase
  end

  assign tx_byte = tx_hi ? rdata[15:8] : rdata[7:0]; // [RULE13]

  // next state; only reacts to the master, never starts a frame
  always_comb begin
    next_st = st; // [RULE1]
    next_bitcnt = bitcnt;
    next_sh = sh;
    next_idx = idx;
    next_rd = rd;
    next_b_lo = b_lo;
    next_b_hi = b_hi;
    next_armed = armed;
    next_offset = offset;
    next_port = port;
    next_rdata = rdata;
    next_rdy = rdy;
    next_tx_hi = tx_hi;
    next_m_ack = m_ack;
    next_sda_oe = sda_oe;
    next_scl_oe = scl_oe;
    next_wr_pulse = 1'b0;
    next_rd_pulse = 1'b0;
    next_wdata = wdata;
    if (cfg_rvalid_in) begin
      next_rdata = cfg_rdata_in;
      next_rdy = 1'b1;
    end
    if (bus_start) begin
      // a repeated start restarts byte counting
      next_st = D_RX; // [RULE12]
      next_bitcnt = 4'h0;
      next_idx = 3'h0;
      next_rd = 1'b0;
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
    end else if (bus_stop) begin
      next_st = D_IDLE;
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
      if (!rd && idx == 3'h4) begin
        if (armed) begin
          // data transaction consumes the setup
          next_armed = 1'b0; // [RULE10]
          next_wdata = {b_hi, b_lo}; // [RULE11]
          next_wr_pulse = (port <= PORT_LAST); // [RULE15] [RULE2]
        end else begin
          next_offset = b_lo; // [RULE8] [RULE14]
          next_port = b_hi; // [RULE9]
          next_armed = 1'b1;
        end
      end
    end else begin
      case (st)
        D_RX: begin
          if (scl_rise && bitcnt < 4'h8) begin
            next_sh = {sh[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            if (byte_ok) begin
              next_sda_oe = 1'b1; // pull low for ack [RULE6]
              next_st = D_ACK;
              next_idx = idx + 3'h1;
              if (idx == 3'h2) next_b_lo = sh;
              if (idx == 3'h3) next_b_hi = sh;
              if (idx == 3'h0) begin
                next_rd = (sh[0] == RD_BIT); // [RULE5]
                if (sh[0] == RD_BIT) begin
                  next_armed = 1'b0;
                  next_tx_hi = 1'b0;
                  if (port > PORT_LAST) begin
                    next_rdata = RDATA_RESV; // [RULE15]
                    next_rdy = 1'b1;
                  end else begin
                    next_rd_pulse = 1'b1; // [RULE14]
                    next_rdy = 1'b0;
                  end
                end
              end
            end else begin
              // not driving leaves the line high: a not-ack
              next_st = D_IDLE; // [RULE6]
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_bitcnt = 4'h0;
            if (rd) begin
              next_st = D_HOLD;
              next_scl_oe = 1'b1; // stretch until data is ready [RULE7]
            end else begin
              next_st = D_RX;
            end
          end
        end
        D_HOLD: begin
          // first bit set while the clock is still held low
          if (rdy) begin
            next_sda_oe = ~tx_byte[7];
            next_sh = {tx_byte[6:0], 1'b0};
            next_bitcnt = 4'h1;
            next_st = D_TX;
          end
        end
        D_TX: begin
          // clock goes one cycle after the data bit, never with it
          next_scl_oe = 1'b0; // [RULE7]
          if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              next_sda_oe = 1'b0; // release for master ack
              next_st = D_TACK;
            end else begin
              next_sda_oe = ~sh[7];
              next_sh = {sh[6:0], 1'b0};
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        D_TACK: begin
          if (scl_rise) begin
            next_m_ack = (sda_s == ACK_BIT);
          end else if (scl_fall) begin
            if (m_ack && !tx_hi) begin
              next_tx_hi = 1'b1;
              next_st = D_HOLD;
              next_scl_oe = 1'b1;
            end else begin
              next_st = D_IDLE;
            end
          end
        end
        default: begin
          next_st = D_IDLE;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= D_IDLE;
      bitcnt <= 4'h0;
      sh <= 8'h00;
      idx <= 3'h0;
      rd <= 1'b0;
      b_lo <= 8'h00;
      b_hi <= 8'h00;
      armed <= 1'b0;
      offset <= 8'h00;
      port <= 8'h00;
      rdata <= 16'h0000;
      rdy <= 1'b0;
      tx_hi <= 1'b0;
      m_ack <= 1'b0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      wdata <= 16'h0000;
    end else begin
      st <= next_st;
      bitcnt <= next_bitcnt;
      sh <= next_sh;
      idx <= next_idx;
      rd <= next_rd;
      b_lo <= next_b_lo;
      b_hi <= next_b_hi;
      armed <= next_armed;
      offset <= next_offset;
      port <= next_port;
      rdata <= next_rdata;
      rdy <= next_rdy;
      tx_hi <= next_tx_hi;
      m_ack <= next_m_ack;
      sda_oe <= next_sda_oe;
      scl_oe <= next_scl_oe;
      wr_pulse <= next_wr_pulse;
      rd_pulse <= next_rd_pulse;
      wdata <= next_wdata;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  // open drain: only ever drives low
  assign link.dev_scl_out = 1'b0;
  assign link.dev_scl_oe = scl_oe;
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = sda_oe;
  assign cfg_wr_out = wr_pulse;
  assign cfg_rd_out = rd_pulse;
  assign cfg_offset_out = offset;
  assign cfg_port_out = port;
  assign cfg_wdata_out = wdata;

endmodule : smcfg_dev

/* File: rtl/smcfg_host.sv */
`timescale 1ns/1ps
// ****************************************************
// management link master issuing register accesses
// ****************************************************
module smcfg_host
  import smcfg_pkg::*;
#(
  // clocks per quarter bit; a short value keeps simulations brief
  parameter int QTR_CNT = QTR_CYC
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // management link
  smcfg_if.host link,
  // command
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic cmd_write_in,
  input wire logic [6:0] cmd_addr_in,
  input wire logic [7:0] cmd_offset_in,
  input wire logic [7:0] cmd_port_in,
  input wire logic [15:0] cmd_wdata_in,
  // response
  output logic rsp_valid_out,
  output logic rsp_nack_out,
  output logic [15:0] rsp_rdata_out
);

  typedef enum logic [0:0] {
    H_IDLE = 1'b0,
    H_RUN = 1'b1
  } smcfg_hst_t;

  // ****************************************************
  // synchronisers and quarter-bit tick
  // ****************************************************
  logic scl_m, scl_s, sda_m, sda_s;
  logic [15:0] div;
  logic tick;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      div <= 16'h0000;
    end else begin
      scl_m <= link.scl;
      scl_s <= scl_m;
      sda_m <= link.sda;
      sda_s <= sda_m;
      div <= tick ? 16'h0000 : div + 16'h0001;
    end
  end
  assign tick = (div == 16'(QTR_CNT - 1));

  // ****************************************************
  // transaction script: one line operation per step
  // ****************************************************
  smcfg_hst_t hst, next_hst;
  logic [3:0] step, next_step;
  logic [1:0] ph, next_ph;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] sh, next_sh;
  logic nack, next_nack;
  logic wr, next_wr;
  logic [6:0] addr, next_addr;
  logic [7:0] offset, next_offset;
  logic [7:0] port, next_port;
  logic [15:0] wdata, next_wdata;
  logic [15:0] rdata, next_rdata;
  logic scl_oe, next_scl_oe;
  logic sda_oe, next_sda_oe;
  logic rsp, next_rsp;
  smcfg_op_t op;
  logic [7:0] obyte;
  logic [3:0] last_step;

  // setup transaction, then data write or command plus read
  always_comb begin
    op = SMCFG_OP_TX;
    obyte = 8'h00;
    case (step)
      4'h0, 4'h6: op = SMCFG_OP_START; // [RULE10] [RULE12]
      4'h1, 4'h7: obyte = {addr, WR_BIT}; // [RULE5]
      4'h2, 4'h8: obyte = CMD_CODE;
      4'h3: obyte = offset; // [RULE8]
      4'h4: obyte = port; // [RULE9]
      4'h5: op = SMCFG_OP_STOP;
      4'h9: begin
        if (wr) obyte = wdata[7:0]; // [RULE11]
        else op = SMCFG_OP_START; // repeated start
      end
      4'ha: obyte = wr ? wdata[15:8] : {addr, RD_BIT};
      4'hb: op = wr ? SMCFG_OP_STOP : SMCFG_OP_RX;
      4'hc: begin
        op = SMCFG_OP_RX;
        obyte = 8'h01; // not-ack the final byte
      end
      default: op = SMCFG_OP_STOP;
    endcase
  end
  assign last_step = wr ? 4'hb : 4'hd;

  // four quarter phases per bit; phase 2 waits out clock stretching
  always_comb begin
    next_hst = hst;
    next_step = step;
    next_ph = ph;
    next_bitcnt = bitcnt;
    next_sh = sh;
    next_nack = nack;
    next_wr = wr;
    next_addr = addr;
    next_offset = offset;
    next_port = port;
    next_wdata = wdata;
    next_rdata = rdata;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_rsp = 1'b0;
    case (hst)
      H_IDLE: begin
        if (cmd_valid_in) begin
          next_hst = H_RUN;
          next_wr = cmd_write_in;
          next_addr = cmd_addr_in;
          next_offset = cmd_offset_in;
          next_port = cmd_port_in;
          next_wdata = cmd_wdata_in;
          next_step = 4'h0;
          next_ph = 2'h0;
          next_bitcnt = 4'h0;
          next_nack = 1'b0;
        end
      end
      H_RUN: begin
        if (tick && !(ph == 2'h2 && !scl_s)) begin
          next_ph = ph + 2'h1;
          case (ph)
            2'h0: begin
              if (op == SMCFG_OP_START) next_sda_oe = 1'b0;
              else if (op == SMCFG_OP_STOP) next_sda_oe = 1'b1;
              else if (bitcnt == 4'h8)
                next_sda_oe = (op == SMCFG_OP_RX) && !obyte[0]; // [RULE6]
              else if (op == SMCFG_OP_TX)
                next_sda_oe = ~obyte[~bitcnt[2:0]];
              else next_sda_oe = 1'b0;
            end
            2'h1: next_scl_oe = 1'b0;
            2'h2: begin
              if (op == SMCFG_OP_START) next_sda_oe = 1'b1;
              else if (op == SMCFG_OP_TX && bitcnt == 4'h8)
                next_nack = nack | (sda_s == NACK_BIT); // [RULE6]
              else if (op == SMCFG_OP_RX && bitcnt < 4'h8)
                next_sh = {sh[6:0], sda_s}; // [RULE13]
            end
            default: begin
              if (op == SMCFG_OP_STOP) next_sda_oe = 1'b0;
              else next_scl_oe = 1'b1;
              if ((op == SMCFG_OP_TX || op == SMCFG_OP_RX) &&
                  bitcnt != 4'h8) begin
                next_bitcnt = bitcnt + 4'h1;
              end else begin
                next_bitcnt = 4'h0;
                if (op == SMCFG_OP_RX) begin
                  if (obyte[0]) next_rdata[15:8] = sh;
                  else next_rdata[7:0] = sh;
                end
                if (op == SMCFG_OP_STOP && (step == last_step || nack))
                begin
                  next_hst = H_IDLE;
                  next_rsp = 1'b1;
                end else if (nack) begin
                  next_step = last_step; // abort through a stop
                end else begin
                  next_step = step + 4'h1;
                end
              end
            end
          endcase
        end
      end
      default: next_hst = H_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hst <= H_IDLE;
      step <= 4'h0;
      ph <= 2'h0;
      bitcnt <= 4'h0;
      sh <= 8'h00;
      nack <= 1'b0;
      wr <= 1'b0;
      addr <= 7'h00;
      offset <= 8'h00;
      port <= 8'h00;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rsp <= 1'b0;
    end else begin
      hst <= next_hst;
      step <= next_step;
      ph <= next_ph;
      bitcnt <= next_bitcnt;
      sh <= next_sh;
      nack <= next_nack;
      wr <= next_wr;
      addr <= next_addr;
      offset <= next_offset;
      port <= next_port;
      wdata <= next_wdata;
      rdata <= next_rdata;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      rsp <= next_rsp;
    end
  end

  // outputs; open drain lines only pull low
  assign link.host_scl_out = 1'b0;
  assign link.host_scl_oe = scl_oe;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = sda_oe;
  assign cmd_ready_out = (hst == H_IDLE);
  assign rsp_valid_out = rsp;
  assign rsp_nack_out = nack;
  assign rsp_rdata_out = rdata;

endmodule : smcfg_host

/* File: verification/smcfg_properties.sv */
`timescale 1ns/1ps
// ****************************************************
// link properties, watched beside the interface
// ****************************************************
module smcfg_properties (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // link enables and wired levels
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // both ends let go of the lines once reset is over
  release_idle_a: assert property (
    $fell(rst_in) |-> !dev_scl_oe && !dev_sda_oe && !host_scl_oe
      && !host_sda_oe) else $error("lines held after reset");
  wired_and_a: assert property (
    ((dev_sda_oe || host_sda_oe) == !sda)
      && ((dev_scl_oe || host_scl_oe) == !scl))
    else $error("line level disagrees with enables");
  // start and stop belong to the host alone
  no_start_a: assert property (
    scl && $past(scl) && $changed(sda) |-> !dev_sda_oe
      && !$past(dev_sda_oe)) else $error("device framed the bus");
  // data and ack move only in the low half of a bit
  sda_low_change_a: assert property (
    $changed(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("device moved data with clock high");
  ack_hold_a: assert property (
    dev_sda_oe && $rose(scl) |-> dev_sda_oe [*3])
    else $error("device bit dropped during clock high");
  // stretching only extends a low the host began
  stretch_low_a: assert property (
    $rose(dev_scl_oe) |-> !$past(scl))
    else $error("device pulled a high clock");
  stretch_bound_a: assert property (
    $rose(dev_scl_oe) |-> ##[1:40] !dev_scl_oe)
    else $error("clock stretch too long");
  host_high_a: assert property (
    $fell(host_scl_oe) |=> !host_scl_oe [*8])
    else $error("host clock high phase too short");

  // main scenarios
  cover property ($rose(dev_scl_oe));
  cover property ($rose(dev_sda_oe) && !host_sda_oe);
  cover property (scl && $rose(sda));
endmodule : smcfg_properties

/* File: verification/testbench.sv */
`timescale 1ns/1ps
// ****************************************************
// bench: host and device facing each other
// ****************************************************
module testbench;
  typedef struct packed {
    logic w;
    logic [6:0] a;
    logic [7:0] off;
    logic [7:0] port;
    logic [15:0] wd;
    logic nack;
    logic acc;
    logic [15:0] rd;
  } smcfg_row_t;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] strap = 3'h0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_offset = 8'h00;
  logic [7:0] cmd_port = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic cmd_ready, rsp_valid, rsp_nack, cfg_wr, cfg_rd;
  logic [15:0] rsp_rdata, cfg_wdata;
  logic [7:0] cfg_offset, cfg_port;
  logic [15:0] cfg_rdata = 16'h0000;
  logic cfg_rvalid = 1'b0;
  logic [15:0] mem [0:1023];
  int n_mismatch = 0;
  int num_checks = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  int rd_wait = 0;
  int w0, r0;
  // short quarter bits keep the run within its cycle budget
  localparam int BENCH_QTR = 8;
  smcfg_row_t rows [8] = '{
    '{1'b1, 7'h58, 8'hb4, 8'h01, 16'h1234, 1'b0, 1'b1, 16'h0000},
    '{1'b0, 7'h58, 8'hb4, 8'h01, 16'h0000, 1'b0, 1'b1, 16'h1234},
    '{1'b1, 7'h58, 8'h10, 8'h03, 16'habcd, 1'b0, 1'b0, 16'h0000},
    '{1'b0, 7'h58, 8'h10, 8'h03, 16'h0000, 1'b0, 1'b0, 16'h0000},
    '{1'b1, 7'h59, 8'h10, 8'h00, 16'h5555, 1'b1, 1'b0, 16'h0000},
    '{1'b1, 7'h58, 8'hff, 8'h02, 16'h8001, 1'b0, 1'b1, 16'h0000},
    '{1'b0, 7'h58, 8'hff, 8'h02, 16'h0000, 1'b0, 1'b1, 16'h8001},
    '{1'b0, 7'h58, 8'hb4, 8'h00, 16'h0000, 1'b0, 1'b1, 16'h5a5a}};

  always #2.5 clk_in = ~clk_in;

  smcfg_if i_smcfg_if ();
  smcfg_dev i_smcfg_dev (.clk_in(clk_in), .rst_in(rst_in),
    .link(i_smcfg_if.dev), .strap_in(strap), .cfg_wr_out(cfg_wr),
    .cfg_rd_out(cfg_rd), .cfg_offset_out(cfg_offset),
    .cfg_port_out(cfg_port), .cfg_wdata_out(cfg_wdata),
    .cfg_rdata_in(cfg_rdata), .cfg_rvalid_in(cfg_rvalid));
  smcfg_host #(.QTR_CNT(BENCH_QTR)) i_smcfg_host (.clk_in(clk_in),
    .rst_in(rst_in), .link(i_smcfg_if.host), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_write_in(cmd_write),
    .cmd_addr_in(cmd_addr), .cmd_offset_in(cmd_offset),
    .cmd_port_in(cmd_port), .cmd_wdata_in(cmd_wdata),
    .rsp_valid_out(rsp_valid), .rsp_nack_out(rsp_nack),
    .rsp_rdata_out(rsp_rdata));
  smcfg_properties i_smcfg_properties (.clk_in(clk_in), .rst_in(rst_in),
    .dev_scl_oe(i_smcfg_if.dev_scl_oe), .dev_sda_oe(i_smcfg_if.dev_sda_oe),
    .host_scl_oe(i_smcfg_if.host_scl_oe),
    .host_sda_oe(i_smcfg_if.host_sda_oe),
    .scl(i_smcfg_if.scl), .sda(i_smcfg_if.sda));

  // register file; reads answer late so the device must stretch
  always @(posedge clk_in) begin
    cfg_rvalid <= (rd_wait == 1);
    if (cfg_wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      if (cfg_port < 8'h03) mem[{cfg_port[1:0], cfg_offset}] <= cfg_wdata;
    end
    if (cfg_rd === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
      rd_wait <= 50; // longer than a bit, so the clock is really held
    end else if (rd_wait != 0) begin
      rd_wait <= rd_wait - 1;
    end
    if (rd_wait == 1) begin
      cfg_rdata <= mem[{cfg_port[1:0], cfg_offset}];
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk

  // one command through the host, bounded wait for its answer
  task automatic run_cmd(input smcfg_row_t r);
    int n;
    n = 0;
    w0 = wr_cnt;
    r0 = rd_cnt;
    @(posedge clk_in);
    #1;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk_in);
      #1;
    end
    {cmd_valid, cmd_write, cmd_addr} = {1'b1, r.w, r.a};
    {cmd_offset, cmd_port, cmd_wdata} = {r.off, r.port, r.wd};
    @(posedge clk_in);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 6000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("rsp_valid", 16'h1, 16'(rsp_valid));
    // the device acts a few clocks after the stop reaches it
    repeat (8) @(posedge clk_in);
    #1;
  endtask : run_cmd

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // watchdog: about three times the expected length of the run
  initial begin
    #400_000;
    $display("[ERR] watchdog expected done seen timeout");
    n_mismatch++;
    print_verdict();
  end

  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 16'h5a5a;
    repeat (6) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    for (int i = 0; i < 8; i++) begin
      run_cmd(rows[i]);
      chk("nack", 16'(rows[i].nack), 16'(rsp_nack));
      if (rows[i].w) begin
        chk("writes", 16'(rows[i].acc), 16'(wr_cnt - w0));
        if (rows[i].acc) begin
          chk("offset", 16'(rows[i].off), 16'(cfg_offset));
          chk("port", 16'(rows[i].port), 16'(cfg_port));
          chk("wdata", rows[i].wd, cfg_wdata);
        end
      end else begin
        chk("reads", 16'(rows[i].acc), 16'(rd_cnt - r0));
        chk("rdata", rows[i].rd, rsp_rdata);
      end
    end
    // straps move the address; the old address must go unanswered
    strap = 3'h5;
    repeat (4) @(posedge clk_in);
    run_cmd('{1'b1, 7'h5d, 8'h20, 8'h00, 16'h0f0e, 1'b0, 1'b1, 16'h0});
    chk("strap nack", 16'h0, 16'(rsp_nack));
    chk("strap wdata", 16'h0f0e, cfg_wdata);
    run_cmd('{1'b1, 7'h58, 8'h20, 8'h00, 16'h0f0e, 1'b0, 1'b1, 16'h0});
    chk("old addr nack", 16'h1, 16'(rsp_nack));
    // reset in mid-run, while the host aborts a refused address
    cmd_valid = 1'b1;
    @(posedge clk_in);
    #1;
    cmd_valid = 1'b0;
    for (int k = 0; k < 600 && rsp_nack !== 1'b1; k++) begin
      @(posedge clk_in);
      #1;
    end
    chk("nack seen", 16'h1, 16'(rsp_nack));
    chk("busy", 16'h0, 16'(cmd_ready));
    rst_in = 1'b1;
    repeat (6) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    @(posedge clk_in);
    #1;
    chk("lines", 16'h3, 16'({i_smcfg_if.scl, i_smcfg_if.sda}));
    chk("ready", 16'h1, 16'(cmd_ready));
    chk("nack reset", 16'h0, 16'(rsp_nack));
    // both ends start clean: read back the strap write
    run_cmd('{1'b0, 7'h5d, 8'h20, 8'h00, 16'h0, 1'b0, 1'b1, 16'h0});
    chk("reset nack", 16'h0, 16'(rsp_nack));
    chk("reset rdata", 16'h0f0e, rsp_rdata);
    print_verdict();
  end
endmodule : testbench
